// >>> bench/sfsb_bank_monitor.sv
// Checker of the fault and status bank, watching its ports only.
// Assumes one clock domain, bound onto every sfsb_bank instance.
`timescale 1ns/1ns
`default_nettype none

module sfsb_bank_monitor
  import sfsb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sfsb_bus_req_s bus_req,
  input wire logic bus_hit,
  input wire logic [7:0] rd_data_q,
  input wire sfsb_fault_in_s fault_in,
  input wire logic selftest_start,
  input wire logic selftest_done,
  input wire sfsb_bist_s selftest_result,
  input wire logic cfg_load_done,
  input wire logic cfg_single_err,
  input wire logic cfg_double_err,
  input wire logic failsafe_req,
  input wire logic failsafe,
  input wire logic active
);
  // ==========================================================================
  // Accepted accesses per register
  wire rd24 = clk_en && bus_req.rd_en && bus_req.addr == 8'h24;
  wire rd30 = clk_en && bus_req.rd_en && bus_req.addr == 8'h30;
  wire rd31 = clk_en && bus_req.rd_en && bus_req.addr == 8'h31;
  wire wr24 = clk_en && bus_req.wr_en && bus_req.addr == 8'h24;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Properties
  property p_unmapped; clk_en && bus_req.rd_en && !bus_hit |=> rd_data_q == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_fault_set;
    clk_en ##1 rd24 |=> (rd_data_q[6] || !$past(fault_in[5], 2)) &&
      ((rd_data_q[4:0] & $past(fault_in[4:0], 2)) == $past(fault_in[4:0], 2));
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not set");
  property p_sticky;
    rd24 && !bus_req.wr_en ##1 rd24 |=> (rd_data_q & $past(rd_data_q)) == $past(rd_data_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag dropped");
  property p_set_wins;
    wr24 && bus_req.wdata[0] && fault_in.watchdog ##1 rd24 |=> rd_data_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag cleared under fault");
  property p_clear;
    wr24 && bus_req.wdata == 8'hFF && fault_in == '0 ##1 rd24 && fault_in == '0
      |=> (rd_data_q & 8'hDF) == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_dbl; clk_en && cfg_load_done && cfg_double_err |=> failsafe && !active; endproperty
  a_dbl: assert property (p_dbl) else $error("no failsafe on double error");
  property p_state;
    rd30 |=> rd_data_q[7] == $past(failsafe) && rd_data_q[2] == $past(active);
  endproperty
  a_state: assert property (p_state) else $error("state bits wrong");
  property p_st_run;
    clk_en && selftest_start && active && !failsafe_req && !cfg_load_done ##1 rd30
      |=> !rd_data_q[6] && !rd_data_q[2];
  endproperty
  a_st_run: assert property (p_st_run) else $error("self-test state bits wrong");
  property p_cfg;
    clk_en && cfg_load_done ##1 rd31
      |=> rd_data_q[5] == $past(cfg_single_err, 2) && rd_data_q[4] == $past(cfg_double_err, 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("load error bits wrong");
  property p_bist;
    clk_en && selftest_done && !active && !failsafe ##1 rd31
      |=> rd_data_q[3:0] == $past(selftest_result, 2);
  endproperty
  a_bist: assert property (p_bist)
    else $error("self-test result bits wrong");

  // ==========================================================================
  // Main scenarios reached
  c_failsafe: cover property (clk_en && cfg_load_done && cfg_double_err);
  c_selftest: cover property (clk_en && selftest_done && !active && !failsafe);
  c_clear: cover property (wr24 && fault_in == '0);
endmodule : sfsb_bank_monitor

bind sfsb_bank sfsb_bank_monitor u_sfsb_bank_monitor (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req), .bus_hit(bus_hit),
  .rd_data_q(rd_data_q), .fault_in(fault_in), .selftest_start(selftest_start),
  .selftest_done(selftest_done), .selftest_result(selftest_result),
  .cfg_load_done(cfg_load_done), .cfg_single_err(cfg_single_err),
  .cfg_double_err(cfg_double_err), .failsafe_req(failsafe_req), .failsafe(failsafe),
  .active(active)
);
`default_nettype wire

// >>> bench/sfsb_host_model.sv
// Host side: serial bus controller reduced to the bank's strobe port.
// Assumes callers enter xfer just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none

module sfsb_host_model
  import sfsb_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rd_data_q,
  output var sfsb_bus_req_s bus_req
);
  // ==========================================================================
  // Idle bus with no strobe, parked on address A5 and data 5A
  initial bus_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: 8'hA5, wdata: 8'h5A};

  // One access held on the bus until the next call; read data taken after one rising edge, once landed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    bus_req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: wr ? d : ~a};
    @(negedge clk);
    q = rd_data_q;
  endtask : xfer
endmodule : sfsb_host_model
`default_nettype wire

// >>> bench/test_sfsb_bank.sv
// Testbench of the fault and status bank driven through the host model.
// Assumes the monitor is bound from its own file.
`timescale 1ns/1ns
`default_nettype none

module test_sfsb_bank
  import sfsb_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  sfsb_bus_req_s bus_req;
  logic bus_hit;
  logic [7:0] rd_data_q;
  sfsb_fault_in_s fault_in = '0;
  logic drv_low = 1'b0;
  logic readback = 1'b1;
  logic clk_en = 1'b1;
  logic supply = 1'b1;
  logic irq = 1'b1;
  logic st_start = 1'b0;
  logic st_done = 1'b0;
  sfsb_bist_s st_res = '0;
  logic cfg_done = 1'b0;
  logic cfg_sec = 1'b0;
  logic cfg_ded = 1'b0;
  logic failsafe;
  logic active;
  int miscompares = 0;
  int checks_done = 0;

  // ==========================================================================
  // Design, host and clock
  sfsb_bank u_sfsb_bank (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req),
    .bus_hit(bus_hit), .rd_data_q(rd_data_q), .fault_in(fault_in), .reset_drive_low(drv_low),
    .reset_pin_readback(readback), .supply_ok(supply), .irq_pin_level(irq),
    .selftest_start(st_start), .selftest_done(st_done), .selftest_result(st_res),
    .cfg_load_done(cfg_done), .cfg_single_err(cfg_sec), .cfg_double_err(cfg_ded),
    .failsafe_req(1'b0), .failsafe(failsafe), .active(active));
  sfsb_host_model u_sfsb_host_model (.clk(clk), .rd_data_q(rd_data_q), .bus_req(bus_req));
  initial begin
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Compare, access and closing tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    logic [7:0] q;
    u_sfsb_host_model.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("register %h", a), exp, q & m);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_sfsb_host_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic test_done;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog: the tests need under a hundred cycles
  initial begin
    #(3000 * 100);
    miscompares++;
    test_done();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    logic [7:0] acc;
    acc = 8'h00;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h24, 8'h00);
    rd(8'h30, 8'h7E);
    rd(8'h31, 8'h00);
    chk("mapped bus hit", 8'h01, {7'h00, bus_hit});
    rd(8'h25, 8'h00);
    chk("unmapped bus hit", 8'h00, {7'h00, bus_hit});
    $display("test reset values done");
    // One-cycle fault per source, flags accumulate
    for (int i = 0; i < 6; i++) begin
      fault_in = sfsb_fault_in_s'(6'h01 << i);
      @(negedge clk);
      fault_in = '0;
      acc[i == 5 ? 6 : i] = 1'b1;
      rd(8'h24, acc);
    end
    wr(8'h24, 8'h00);
    rd(8'h24, 8'h5F);
    fault_in.watchdog = 1'b1;
    wr(8'h24, 8'h01);
    rd(8'h24, 8'h5F);
    fault_in.watchdog = 1'b0;
    wr(8'h24, 8'hFF);
    rd(8'h24, 8'h00);
    // A fault seen only while the clock enable is low leaves no trace
    clk_en = 1'b0;
    fault_in.watchdog = 1'b1;
    @(negedge clk);
    fault_in.watchdog = 1'b0;
    clk_en = 1'b1;
    rd(8'h24, 8'h00);
    $display("test fault flags done");
    // Driving low while reading high: flag only after the blanking span
    drv_low = 1'b1;
    repeat (21) @(negedge clk);
    rd(8'h24, 8'h00);
    rd(8'h24, 8'h20);
    wr(8'h24, 8'h20);
    rd(8'h24, 8'h20);
    readback = 1'b0;
    wr(8'h24, 8'h20);
    rd(8'h24, 8'h00);
    drv_low = 1'b0;
    readback = 1'b1;
    $display("test reset pin mismatch done");
    // Corrected load error, then a self-test round
    cfg_sec = 1'b1;
    cfg_done = 1'b1;
    @(negedge clk);
    cfg_done = 1'b0;
    rd(8'h31, 8'h20);
    st_start = 1'b1;
    @(negedge clk);
    st_start = 1'b0;
    rd(8'h30, 8'h3A);
    st_res = sfsb_bist_s'(4'hA);
    st_done = 1'b1;
    @(negedge clk);
    st_done = 1'b0;
    rd(8'h31, 8'h2A);
    rd(8'h30, 8'h7E);
    wr(8'h31, 8'hFF);
    rd(8'h31, 8'h2A);
    $display("test self-test done");
    // Uncorrectable load error forces failsafe
    cfg_sec = 1'b0;
    cfg_ded = 1'b1;
    cfg_done = 1'b1;
    @(negedge clk);
    cfg_done = 1'b0;
    chk("failsafe and active pins", 8'h02, {6'h00, failsafe, active});
    rd(8'h31, 8'h1A);
    rd(8'h30, 8'h80, 8'h84);
    // Supply and interrupt pin low show through one edge later
    supply = 1'b0;
    irq = 1'b0;
    @(negedge clk);
    rd(8'h30, 8'h8A, 8'hBF);
    $display("test failsafe done");
    test_done();
  end
endmodule : test_sfsb_bank
`default_nettype wire

// >>> rtl/sfsb_bank.sv
// Safety fault and status register bank: sticky vendor fault flags, device state
// status and self-test results, reached through the serial bus register port.
// Assumes the serial bus engine decodes frames into one-cycle read/write strobes
// on clk, and that all monitor inputs are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "sfsb_map.svh"

module sfsb_bank
  import sfsb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sfsb_bus_req_s bus_req,
  output logic bus_hit,
  output logic [7:0] rd_data_q,
  input wire sfsb_fault_in_s fault_in,
  input wire logic reset_drive_low,
  input wire logic reset_pin_readback,
  input wire logic supply_ok,
  input wire logic irq_pin_level,
  input wire logic selftest_start,
  input wire logic selftest_done,
  input wire sfsb_bist_s selftest_result,
  input wire logic cfg_load_done,
  input wire logic cfg_single_err,
  input wire logic cfg_double_err,
  input wire logic failsafe_req,
  output logic failsafe,
  output logic active
);

  localparam logic [4:0] BLANK_CYC = 5'(`SFSB_MISMATCH_BLANK_CYC);

  // ========================================================================
  // Helpers

  // Sticky flag update: a live fault sets, a write-1 clears only when idle
  function automatic logic sticky_next(
    input logic flag,
    input logic fault_now,
    input logic clear_req
  );
    logic keep;
    keep = flag & ~(clear_req & ~fault_now);
    return keep | fault_now;
  endfunction : sticky_next

  // Register address decode
  function automatic logic is_addr(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return addr == off;
  endfunction : is_addr

  // ========================================================================
  // Access decode
  logic wr_fault;
  logic [7:0] clr_mask;

  // Write strobe aimed at the fault flag register, with its clear mask
  always_comb begin
    wr_fault = bus_req.wr_en & is_addr(bus_req.addr, `SFSB_OFF_VENDOR_FAULT_FLAGS);
    clr_mask = wr_fault ? bus_req.wdata : 8'h00;
  end

  // ========================================================================
  // Reset pin mismatch blanking
  logic drive_prev_q;
  logic drive_prev_d;
  logic [4:0] blank_cnt_q;
  logic [4:0] blank_cnt_d;
  logic mismatch_now;

  // Restart the 2us blanking window on every change of the driven state
  always_comb begin
    drive_prev_d = reset_drive_low;
    blank_cnt_d = blank_cnt_q;
    if (reset_drive_low != drive_prev_q) begin
      blank_cnt_d = BLANK_CYC;
    end else if (blank_cnt_q != 5'h00) begin
      blank_cnt_d = blank_cnt_q - 5'h01;
    end
  end

  // Compare driven level with readback once the window has run out
  always_comb begin
    mismatch_now = 1'b0;
    if ((blank_cnt_q == 5'h00) && (reset_drive_low == drive_prev_q)) begin
      mismatch_now = reset_drive_low == reset_pin_readback;
    end
  end

  // Blanking state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_prev_q <= 1'b0;
      blank_cnt_q <= 5'h00;
    end else if (clk_en) begin
      drive_prev_q <= drive_prev_d;
      blank_cnt_q <= blank_cnt_d;
    end
  end

  // ========================================================================
  // Sticky vendor fault flags
  logic [7:0] fault_q;
  logic [7:0] fault_d;

  // Each flag follows the sticky rule; the set wins over a same-cycle clear
  always_comb begin
    fault_d = 8'h00;
    fault_d[`SFSB_BIT_REGULATOR_OV] = sticky_next(fault_q[`SFSB_BIT_REGULATOR_OV],
      fault_in.regulator_ov, clr_mask[`SFSB_BIT_REGULATOR_OV]);
    fault_d[`SFSB_BIT_RESET_MISMATCH] = sticky_next(fault_q[`SFSB_BIT_RESET_MISMATCH],
      mismatch_now, clr_mask[`SFSB_BIT_RESET_MISMATCH]);
    fault_d[`SFSB_BIT_CLOCK_DEV] = sticky_next(fault_q[`SFSB_BIT_CLOCK_DEV],
      fault_in.clock_dev, clr_mask[`SFSB_BIT_CLOCK_DEV]);
    fault_d[`SFSB_BIT_ADDR_SHORT] = sticky_next(fault_q[`SFSB_BIT_ADDR_SHORT],
      fault_in.addr_short, clr_mask[`SFSB_BIT_ADDR_SHORT]);
    fault_d[`SFSB_BIT_ADDR_OPEN] = sticky_next(fault_q[`SFSB_BIT_ADDR_OPEN],
      fault_in.addr_open, clr_mask[`SFSB_BIT_ADDR_OPEN]);
    fault_d[`SFSB_BIT_ERROR_SIGNAL] = sticky_next(fault_q[`SFSB_BIT_ERROR_SIGNAL],
      fault_in.error_signal, clr_mask[`SFSB_BIT_ERROR_SIGNAL]);
    fault_d[`SFSB_BIT_WATCHDOG] = sticky_next(fault_q[`SFSB_BIT_WATCHDOG],
      fault_in.watchdog, clr_mask[`SFSB_BIT_WATCHDOG]);
  end

  // Fault flag register; flags survive recovery of the fault
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_q <= `SFSB_RST_VENDOR_FAULT_FLAGS;
    end else if (clk_en) begin
      fault_q <= fault_d;
    end
  end

  // ========================================================================
  // Device state machine
  sfsb_state_e state_q;
  sfsb_state_e state_d;
  logic bist_done_q;
  logic bist_done_d;

  // Self-test runs from active; failsafe is left only through reset
  always_comb begin
    state_d = state_q;
    bist_done_d = bist_done_q;
    case (state_q)
      SFSB_SELFTEST: begin
        if (selftest_done) begin
          state_d = SFSB_ACTIVE;
          bist_done_d = 1'b1;
        end
      end
      SFSB_ACTIVE: begin
        if (selftest_start) begin
          state_d = SFSB_SELFTEST;
          bist_done_d = 1'b0;
        end
      end
      SFSB_FAILSAFE: begin
        state_d = SFSB_FAILSAFE;
      end
      default: begin
        state_d = SFSB_FAILSAFE;
      end
    endcase
    if (failsafe_req || (cfg_load_done && cfg_double_err)) begin
      state_d = SFSB_FAILSAFE;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SFSB_ACTIVE;
      bist_done_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      bist_done_q <= bist_done_d;
    end
  end

  // ========================================================================
  // Sampled pin status
  logic supply_q;
  logic supply_d;
  logic irq_pin_q;
  logic irq_pin_d;

  // Next pin status levels, taken straight from the pins
  always_comb begin
    supply_d = supply_ok;
    irq_pin_d = irq_pin_level;
  end

  // Supply and interrupt pin levels as seen by software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      supply_q <= 1'b1;
      irq_pin_q <= 1'b1;
    end else if (clk_en) begin
      supply_q <= supply_d;
      irq_pin_q <= irq_pin_d;
    end
  end

  // ========================================================================
  // Self-test and configuration load results
  logic [7:0] result_q;
  logic [7:0] result_d;

  // Configuration load and self-test each refresh only their own bits
  always_comb begin
    result_d = result_q;
    if (cfg_load_done) begin
      result_d[`SFSB_BIT_SINGLE_ERR] = cfg_single_err;
      result_d[`SFSB_BIT_DOUBLE_ERR] = cfg_double_err;
    end
    if (selftest_done && (state_q == SFSB_SELFTEST)) begin
      result_d[`SFSB_BIT_VOLATILE_FAIL] = selftest_result.volatile_mem_test_fail;
      result_d[`SFSB_BIT_NONVOLATILE_FAIL] =
        selftest_result.nonvolatile_mem_test_fail;
      result_d[`SFSB_BIT_LOGIC_FAIL] = selftest_result.logic_test_fail;
      result_d[`SFSB_BIT_ANALOG_FAIL] = selftest_result.analog_test_fail;
    end
    result_d[7:6] = 2'b00;
  end

  // Result register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= `SFSB_RST_SELF_TEST_RESULTS;
    end else if (clk_en) begin
      result_q <= result_d;
    end
  end

  // ========================================================================
  // Read path
  logic [7:0] state_word;
  logic [7:0] rd_data_d;

  // Device state word; reserved bits 3 and 1 read 1, bit 0 reads 0
  always_comb begin
    state_word = `SFSB_STATE_RSVD_MASK;
    state_word[`SFSB_BIT_FAILSAFE] = state_q == SFSB_FAILSAFE;
    state_word[`SFSB_BIT_SELFTEST_DONE] = bist_done_q;
    state_word[`SFSB_BIT_SUPPLY_OK] = supply_q;
    state_word[`SFSB_BIT_IRQ_PIN] = irq_pin_q;
    state_word[`SFSB_BIT_ACTIVE] = state_q == SFSB_ACTIVE;
  end

  // Address decode for reads and hit indication
  always_comb begin
    rd_data_d = rd_data_q;
    bus_hit = 1'b1;
    if (is_addr(bus_req.addr, `SFSB_OFF_VENDOR_FAULT_FLAGS)) begin
      if (bus_req.rd_en) begin
        rd_data_d = fault_q;
      end
    end else if (is_addr(bus_req.addr, `SFSB_OFF_DEVICE_STATE_STATUS)) begin
      if (bus_req.rd_en) begin
        rd_data_d = state_word;
      end
    end else if (is_addr(bus_req.addr, `SFSB_OFF_SELF_TEST_RESULTS)) begin
      if (bus_req.rd_en) begin
        rd_data_d = result_q;
      end
    end else begin
      bus_hit = 1'b0;
      if (bus_req.rd_en) begin
        rd_data_d = `SFSB_UNMAPPED_DATA;
      end
    end
  end

  // Read data register, updated only on a read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else if (clk_en) begin
      rd_data_q <= rd_data_d;
    end
  end

  // ========================================================================
  // State outputs
  always_comb begin
    failsafe = state_q == SFSB_FAILSAFE;
    active = state_q == SFSB_ACTIVE;
  end

endmodule : sfsb_bank

`default_nettype wire

// >>> rtl/sfsb_map.svh
// Constants of the safety fault and status register bank: offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SFSB_MAP_SVH
`define SFSB_MAP_SVH

// ==========================================================================
// Register offsets
`define SFSB_OFF_VENDOR_FAULT_FLAGS 8'h24
`define SFSB_OFF_DEVICE_STATE_STATUS 8'h30
`define SFSB_OFF_SELF_TEST_RESULTS 8'h31

// ==========================================================================
// Reset values
`define SFSB_RST_VENDOR_FAULT_FLAGS 8'h00
`define SFSB_RST_DEVICE_STATE_STATUS 8'h7E
`define SFSB_RST_SELF_TEST_RESULTS 8'h00
`define SFSB_UNMAPPED_DATA 8'h00

// ==========================================================================
// Vendor fault flag bit positions
`define SFSB_BIT_REGULATOR_OV 6
`define SFSB_BIT_RESET_MISMATCH 5
`define SFSB_BIT_CLOCK_DEV 4
`define SFSB_BIT_ADDR_SHORT 3
`define SFSB_BIT_ADDR_OPEN 2
`define SFSB_BIT_ERROR_SIGNAL 1
`define SFSB_BIT_WATCHDOG 0

// ==========================================================================
// Device state status bit positions; bits 3 and 1 are reserved and read 1
`define SFSB_BIT_FAILSAFE 7
`define SFSB_BIT_SELFTEST_DONE 6
`define SFSB_BIT_SUPPLY_OK 5
`define SFSB_BIT_IRQ_PIN 4
`define SFSB_BIT_ACTIVE 2
`define SFSB_STATE_RSVD_MASK 8'h0A

// ==========================================================================
// Self-test result bit positions
`define SFSB_BIT_SINGLE_ERR 5
`define SFSB_BIT_DOUBLE_ERR 4
`define SFSB_BIT_VOLATILE_FAIL 3
`define SFSB_BIT_NONVOLATILE_FAIL 2
`define SFSB_BIT_LOGIC_FAIL 1
`define SFSB_BIT_ANALOG_FAIL 0

// ==========================================================================
// Timing: clock period and reset pin mismatch blanking after a toggle
`define SFSB_CLK_PERIOD_NS 100
`define SFSB_MISMATCH_BLANK_NS 2000
`define SFSB_MISMATCH_BLANK_CYC \
  ((`SFSB_MISMATCH_BLANK_NS + `SFSB_CLK_PERIOD_NS - 1) / `SFSB_CLK_PERIOD_NS)

`endif

// >>> rtl/sfsb_pkg.sv
// Types of the safety fault and status register bank.
// Assumes no other package; constants live in sfsb_map.svh.
package sfsb_pkg;

  // ========================================================================
  // Register access request from the serial bus engine
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfsb_bus_req_s;

  // ========================================================================
  // Live fault levels from the monitors, high while a fault is present
  typedef struct packed {
    logic regulator_ov;
    logic clock_dev;
    logic addr_short;
    logic addr_open;
    logic error_signal;
    logic watchdog;
  } sfsb_fault_in_s;

  // ========================================================================
  // Self-test outcome, high means fail
  typedef struct packed {
    logic volatile_mem_test_fail;
    logic nonvolatile_mem_test_fail;
    logic logic_test_fail;
    logic analog_test_fail;
  } sfsb_bist_s;

  // ========================================================================
  // Device operating state
  typedef enum logic [1:0] {
    SFSB_SELFTEST,
    SFSB_ACTIVE,
    SFSB_FAILSAFE
  } sfsb_state_e;

endpackage : sfsb_pkg
